// [coc_defs.svh]
// Offsets, bit positions and reset values of the clock output control bytes
`ifndef COC_DEFS_SVH
`define COC_DEFS_SVH
`define COC_CMD_BYTE_OP       3'h4
`define COC_OFS_PCI           5'h02
`define COC_OFS_GFX_PERIPH    5'h03
`define COC_OFS_PERIPH        5'h04
`define COC_OFS_MEMORY        5'h05
`define COC_NUM_REGS          4
`define COC_RST_PCI           8'h7f
`define COC_RST_GFX_PERIPH    8'h67
`define COC_RST_PERIPH        8'hcf
`define COC_RST_MEMORY        8'h7f
`define COC_DEV_ADDR          7'h69
`define COC_BIT_PCI_STRONG    7
`define COC_BIT_SIO_48        7
`define COC_BIT_USB_EN        6
`define COC_BIT_SIO_EN        5
`define COC_BIT_SKEW_HI       4
`define COC_BIT_SKEW_LO       3
`define COC_BIT_USB_WEAK      7
`define COC_BIT_SIO_WEAK      6
`define COC_BIT_RATIO_HI      5
`define COC_BIT_RATIO_LO      4
`define COC_BIT_REF_CLK0_EN   3
`define COC_BIT_REF_CLK1_EN   2
`define COC_BIT_REF_CLK0_WEAK 1
`define COC_BIT_REF_CLK1_WEAK 0
`define COC_BIT_BUF_THRESH    7
`define COC_BIT_FB_EN         6
`endif

// [coc_pkg.sv]
// Types shared by the clock output control register bank
package coc_pkg;
	typedef enum logic [3:0] {
		COC_IDLE, COC_ADDR, COC_CMD, COC_WDATA, COC_ACKW, COC_ACK, COC_RDATA, COC_RACK, COC_WAITS
	} coc_state_t;

	typedef struct packed {
		logic       pciStrong;
		logic [6:0] pciEn;
		logic       sio48;
		logic       usbEn;
		logic       sioEn;
		logic [1:0] gfxSkew;
		logic [2:0] gfxEn;
		logic       usbWeak;
		logic       sioWeak;
		logic [1:0] gfxRatio;
		logic       referenceClock0En;
		logic       referenceClock1En;
		logic       referenceClock0Weak;
		logic       referenceClock1Weak;
		logic       bufLowThresh;
		logic       fbEn;
		logic [5:0] memEn;
	} coc_ctl_t;
endpackage

// [coc_clock_output_control_regs.sv]
// Serial-bus slave and the four clock output control bytes
`include "coc_defs.svh"

module coc_clock_output_control_regs #(
	parameter logic [6:0] DEV_ADDR = `COC_DEV_ADDR // Arbitrary default bus address
) (
	input  wire logic            clk,
	input  wire logic            nrst,
	input  wire logic            scl,
	input  wire logic            sdaIn,
	output logic                 sdaOut,
	output logic                 sdaOe_n,
	input  wire logic            alternateCpuMode,
	output coc_pkg::coc_ctl_t    clkCtl
);
	import coc_pkg::*;

	logic [1:0] rstSync;
	logic       rstN;
	logic [1:0] sclSync, sdaSync, modeSync;
	logic       sclPrev, sdaPrev;
	logic       sclRise, sclFall, startCond, stopCond;

	coc_state_t state_reg, state_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] tx_reg, tx_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [1:0] phase_reg, phase_next;
	logic [4:0] ofs_reg, ofs_next;
	logic       drive_reg, drive_next;
	logic [7:0] cfg_reg [`COC_NUM_REGS];
	logic [7:0] cfg_next [`COC_NUM_REGS];
	logic [7:0] rdByte;
	logic [7:0] shiftIn;
	logic [4:0] idx;

	localparam logic [7:0] RST_VAL [`COC_NUM_REGS] = '{
		`COC_RST_PCI, `COC_RST_GFX_PERIPH, `COC_RST_PERIPH, `COC_RST_MEMORY};

	// Release of reset is synchronised; assertion stays asynchronous
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sclSync  <= 2'h3;
			sdaSync  <= 2'h3;
			modeSync <= 2'h0;
			sclPrev  <= 1'b1;
			sdaPrev  <= 1'b1;
		end else begin
			sclSync  <= {sclSync[0], scl};
			sdaSync  <= {sdaSync[0], sdaIn};
			modeSync <= {modeSync[0], alternateCpuMode};
			sclPrev  <= sclSync[1];
			sdaPrev  <= sdaSync[1];
		end
	end

	assign sclRise   = sclSync[1] & ~sclPrev;
	assign sclFall   = ~sclSync[1] & sclPrev;
	assign startCond = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
	assign stopCond  = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];
	assign shiftIn   = {shift_reg[6:0], sdaSync[1]};
	assign idx       = ofs_reg - `COC_OFS_PCI;

	// Unmapped offsets read as zero
	always_comb begin
		rdByte = 8'h00;
		if (ofs_reg >= `COC_OFS_PCI && ofs_reg <= `COC_OFS_MEMORY) begin
			rdByte = cfg_reg[idx[1:0]];
		end
	end

	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		tx_next    = tx_reg;
		cnt_next   = cnt_reg;
		phase_next = phase_reg;
		ofs_next   = ofs_reg;
		drive_next = drive_reg;
		for (int i = 0; i < `COC_NUM_REGS; i++) begin
			cfg_next[i] = cfg_reg[i];
		end
		if (stopCond) begin
			state_next = COC_IDLE;
			drive_next = 1'b0;
		end else if (startCond) begin
			// Also a repeated start inside a read
			state_next = COC_ADDR;
			cnt_next   = 3'h0;
			drive_next = 1'b0;
		end else begin
			case (state_reg)
				COC_ADDR, COC_CMD, COC_WDATA: begin
					if (sclRise) begin
						shift_next = shiftIn;
						cnt_next   = cnt_reg + 3'h1;
						if (cnt_reg == 3'h7) begin
							state_next = COC_ACKW;
							if (state_reg == COC_ADDR) begin
								phase_next = 2'h0;
								if (shiftIn[7:1] != DEV_ADDR) begin
									state_next = COC_WAITS;
								end
							end else if (state_reg == COC_CMD) begin
								phase_next = 2'h1;
								if (shiftIn[7:5] != `COC_CMD_BYTE_OP) begin
									state_next = COC_WAITS;
								end else begin
									ofs_next = shiftIn[4:0];
								end
							end else begin
								phase_next = 2'h2;
								if (ofs_reg >= `COC_OFS_PCI && ofs_reg <= `COC_OFS_MEMORY) begin
									cfg_next[idx[1:0]] = shiftIn;
								end
							end
						end
					end
				end
				COC_ACKW: begin
					if (sclFall) begin
						drive_next = 1'b1;
						state_next = COC_ACK;
					end
				end
				COC_ACK: begin
					if (sclFall) begin
						drive_next = 1'b0;
						cnt_next   = 3'h0;
						case (phase_reg)
							2'h0: begin
								if (shift_reg[0]) begin
									state_next = COC_RDATA;
									tx_next    = {rdByte[6:0], 1'b0};
									drive_next = ~rdByte[7];
								end else begin
									state_next = COC_CMD;
								end
							end
							2'h1: state_next = COC_WDATA;
							default: state_next = COC_WAITS;
						endcase
					end
				end
				COC_RDATA: begin
					if (sclRise) begin
						cnt_next = cnt_reg + 3'h1;
						if (cnt_reg == 3'h7) begin
							state_next = COC_RACK;
						end
					end else if (sclFall) begin
						drive_next = ~tx_reg[7];
						tx_next    = {tx_reg[6:0], 1'b0};
					end
				end
				COC_RACK: begin
					// Release for the master's acknowledge; only one byte per read
					if (sclFall) begin
						drive_next = 1'b0;
						state_next = COC_WAITS;
					end
				end
				COC_IDLE, COC_WAITS: begin
					drive_next = 1'b0;
				end
				default: begin
					state_next = COC_IDLE;
					drive_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_reg <= COC_IDLE;
			shift_reg <= 8'h00;
			tx_reg    <= 8'h00;
			cnt_reg   <= 3'h0;
			phase_reg <= 2'h0;
			ofs_reg   <= 5'h00;
			drive_reg <= 1'b0;
			for (int i = 0; i < `COC_NUM_REGS; i++) begin
				cfg_reg[i] <= RST_VAL[i];
			end
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			tx_reg    <= tx_next;
			cnt_reg   <= cnt_next;
			phase_reg <= phase_next;
			ofs_reg   <= ofs_next;
			drive_reg <= drive_next;
			for (int i = 0; i < `COC_NUM_REGS; i++) begin
				cfg_reg[i] <= cfg_next[i];
			end
		end
	end

	// Open drain: only ever pull low
	assign sdaOut  = 1'b0;
	assign sdaOe_n = ~drive_reg;

	// Enables act straight from the byte so a clear stops the output at once
	assign clkCtl.pciStrong    = cfg_reg[0][`COC_BIT_PCI_STRONG];
	assign clkCtl.pciEn        = cfg_reg[0][6:0];
	assign clkCtl.sio48        = cfg_reg[1][`COC_BIT_SIO_48];
	assign clkCtl.usbEn        = cfg_reg[1][`COC_BIT_USB_EN];
	assign clkCtl.sioEn        = cfg_reg[1][`COC_BIT_SIO_EN];
	assign clkCtl.gfxSkew      = cfg_reg[1][`COC_BIT_SKEW_HI:`COC_BIT_SKEW_LO];
	assign clkCtl.gfxEn        = cfg_reg[1][2:0];
	assign clkCtl.usbWeak      = cfg_reg[2][`COC_BIT_USB_WEAK];
	assign clkCtl.sioWeak      = cfg_reg[2][`COC_BIT_SIO_WEAK];
	assign clkCtl.gfxRatio     = cfg_reg[2][`COC_BIT_RATIO_HI:`COC_BIT_RATIO_LO];
	assign clkCtl.referenceClock0En   = cfg_reg[2][`COC_BIT_REF_CLK0_EN];
	assign clkCtl.referenceClock1En   = cfg_reg[2][`COC_BIT_REF_CLK1_EN];
	assign clkCtl.referenceClock0Weak = cfg_reg[2][`COC_BIT_REF_CLK0_WEAK];
	assign clkCtl.referenceClock1Weak = cfg_reg[2][`COC_BIT_REF_CLK1_WEAK] & modeSync[1];
	assign clkCtl.bufLowThresh = cfg_reg[3][`COC_BIT_BUF_THRESH];
	assign clkCtl.fbEn         = cfg_reg[3][`COC_BIT_FB_EN];
	assign clkCtl.memEn        = cfg_reg[3][5:0];
endmodule

// [coc_smb_host.sv]
// Serial-bus host model driving the clock control slave
module coc_smb_host (
	input  wire logic clk,
	input  wire logic sdaLine,
	output logic      scl,
	output logic      sdaDrv
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// SDA only moves mid-low; a released line reads the pull-up
	task automatic bitIo(input logic b, output logic s);
		sdaDrv <= b;
		tick(4);
		scl <= 1'b1;
		tick(6);
		s = sdaLine;
		tick(2);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic edgeSda(input logic lvl);
		sdaDrv <= ~lvl;
		tick(4);
		scl <= 1'b1;
		tick(8);
		sdaDrv <= lvl;
		tick(8);
	endtask
	task automatic start();
		edgeSda(1'b0);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic byteIo(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
		bitIo(1'b1, a);
		ack = ~a;
	endtask
	task automatic xfer(input logic [6:0] addr, input logic rd, input logic [7:0] cmd,
		input logic [7:0] wd, output logic [7:0] q, output logic [2:0] acks);
		logic [7:0] junk;
		start();
		byteIo({addr, 1'b0}, junk, acks[2]);
		byteIo(cmd, junk, acks[1]);
		q = 8'h00;
		if (rd) begin
			start();
			byteIo({addr, 1'b1}, junk, acks[0]);
			byteIo(8'hff, q, junk[0]);
		end else begin
			byteIo(wd, junk, acks[0]);
		end
		edgeSda(1'b1);
	endtask
endmodule

// [coc_regs_asserts.sv]
// Port checks for the clock output control slave
`include "coc_defs.svh"
module coc_regs_asserts (
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic              scl,
	input wire logic              sdaIn,
	input wire logic              sdaOut,
	input wire logic              sdaOe_n,
	input wire logic              alternateCpuMode,
	input wire coc_pkg::coc_ctl_t clkCtl
);
	timeunit 1ns;
	timeprecision 1ns;
	import coc_pkg::*;
	// Reference 1 strength follows the mode input, so it is masked out
	localparam logic [31:0] MASK = 32'hffff_feff;
	localparam logic [31:0] RST = {`COC_RST_PCI, `COC_RST_GFX_PERIPH, `COC_RST_PERIPH,
		`COC_RST_MEMORY};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_reset_values: assert property ($rose(nrst) |-> (clkCtl & MASK) == (RST & MASK))
		else $error("control bytes not at power-up values");
	a_write_scl_high: assert property (!$stable(clkCtl & MASK) |-> scl && $past(scl, 2))
		else $error("control byte changed outside a data bit");
	a_write_sda_free: assert property (!$stable(clkCtl & MASK) |-> sdaOe_n)
		else $error("control byte changed while slave drives the line");
	a_strength_gated: assert property (!alternateCpuMode [*4] |=> !clkCtl.referenceClock1Weak)
		else $error("reference 1 strength active outside alternate mode");
	a_strength_cause: assert property (clkCtl.referenceClock1Weak |-> $past(alternateCpuMode, 2) ||
		$past(alternateCpuMode, 3) || $past(alternateCpuMode, 4))
		else $error("reference 1 strength set without mode");
	a_open_drain: assert property (sdaOut == 1'b0)
		else $error("data pin driven high");
	a_sda_scl_low: assert property (!$stable(sdaOe_n) |-> !scl)
		else $error("slave moved data while clock high");
	a_drive_late: assert property ($fell(sdaOe_n) |-> !$past(scl, 2))
		else $error("slave drove data too soon after clock fall");
	a_drive_holds: assert property ($fell(sdaOe_n) |-> !sdaOe_n [*8])
		else $error("acknowledge or data bit not held");
	c_write: cover property (!$stable(clkCtl & MASK));
	c_ack: cover property ($fell(sdaOe_n));
	c_mode_strength: cover property ($rose(clkCtl.referenceClock1Weak));
	c_start: cover property (scl && $fell(sdaIn));
endmodule
bind coc_clock_output_control_regs coc_regs_asserts coc_regs_asserts_inst (
	.clk(clk), .nrst(nrst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
	.alternateCpuMode(alternateCpuMode), .clkCtl(clkCtl));

// [tb.sv]
// Self-checking bench for the clock output control register bank
`include "coc_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import coc_pkg::*;
	logic       clk, nrst, mode, hostScl, hostSda, sdaOut, sdaOe_n;
	wire        sdaLine = sdaOe_n ? hostSda : 1'b0;
	coc_ctl_t   clkCtl;
	logic [7:0] rd;
	logic [2:0] acks;
	logic [7:0] b [2:5];
	int         failures, samplesChecked;
	coc_clock_output_control_regs coc_clock_output_control_regs_inst (
		.clk(clk), .nrst(nrst), .scl(hostScl), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOe_n(sdaOe_n), .alternateCpuMode(mode), .clkCtl(clkCtl));
	coc_smb_host coc_smb_host_inst (.clk(clk), .sdaLine(sdaLine), .scl(hostScl), .sdaDrv(hostSda));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		coc_smb_host_inst.xfer(`COC_DEV_ADDR, 1'b0, cmd, d, rd, acks);
	endtask
	task automatic rdb(input logic [7:0] cmd);
		coc_smb_host_inst.xfer(`COC_DEV_ADDR, 1'b1, cmd, 8'h00, rd, acks);
	endtask
	task automatic checkCtl();
		check("ctl", clkCtl, {b[2], b[3], b[4][7:1], b[4][0] & mode, b[5]});
	endtask
	task automatic checkAll();
		for (int i = 2; i <= 5; i++) begin
			rdb({3'h4, 5'(i)});
			check("byte", rd, b[i]);
		end
		checkCtl();
	endtask
	task automatic t_reset();
		b = '{`COC_RST_PCI, `COC_RST_GFX_PERIPH, `COC_RST_PERIPH, `COC_RST_MEMORY};
		check("open drain", sdaOut, 1'b0);
		checkAll();
	endtask
	task automatic t_invert();
		for (int i = 2; i <= 5; i++) begin
			b[i] = ~b[i];
			wr({3'h4, 5'(i)}, b[i]);
			check("acks", acks, 3'b111);
		end
		checkAll();
	endtask
	task automatic t_codes();
		for (int k = 0; k < 4; k++) begin
			b[3] = {3'b101, 2'(k), 3'b010};
			b[4] = {2'b01, 2'(k), 4'h5};
			wr(8'h83, b[3]);
			wr(8'h84, b[4]);
			checkCtl();
		end
	endtask
	task automatic t_mode();
		mode <= 1'b1;
		repeat (6) @(posedge clk);
		checkCtl();
		mode <= 1'b0;
		repeat (6) @(posedge clk);
		checkCtl();
	endtask
	task automatic t_refuse();
		wr(8'h62, 8'h00);
		check("nack", acks, 3'b100);
		wr(8'h86, 8'h55);
		rdb(8'h86);
		check("unmapped", rd, 8'h00);
		coc_smb_host_inst.xfer(~`COC_DEV_ADDR, 1'b0, 8'h82, 8'h00, rd, acks);
		check("addr", acks, 3'b000);
		checkAll();
	endtask
	task automatic wrap_up();
		$display("checked %0d failures %0d", samplesChecked, failures);
		if (failures == 0 && samplesChecked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		nrst = 1'b0;
		mode = 1'b0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		t_reset();
		t_invert();
		t_codes();
		t_mode();
		t_refuse();
		wrap_up();
	end
	initial begin
		repeat (80000) @(posedge clk);
		failures++;
		wrap_up();
	end
endmodule
